// ### design/ssc_defs.svh
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_ADDR_WR 7'h10
`define SSC_IDX_PWR 7'h10
`define SSC_PWR_RST 8'h01
`define SSC_BIT_LP 0
`define SSC_BIT_SRST 2
`define SSC_NIB_IDLE 4'hF
`define SSC_NIB_A 4'h9
`define SSC_NIB_B 4'h6
`define SSC_FRAME_CYC 32'd1000
`define SSC_ONE_BIT 3'h7
`define SSC_IDX_MSB 7
`endif

// ### design/ssc_pkg.sv
package ssc_pkg;
    typedef struct packed {
        logic sclIn;
        logic sdaIn;
    } ssc_bus_in_t;
    typedef enum {SS_IDLE, SS_ADDR, SS_INDEX, SS_WDATA, SS_RDATA, SS_ACKW, SS_ACKR,
                  SS_MACK, SS_IGNORE} ssc_state_t;
    typedef enum {PM_LOW, PM_INIT, PM_RUN} ssc_pmode_t;
endpackage

// ### design/ssc_sensor_ctrl.sv
// Behaviour
// - After reset the device is in low-power mode with nibble bus all ones.
// - Low power exits only with clock running and index 16 bit 0 written.
// - In low power, nibble bus reads all ones and analogue is off.
// - Leaving low power runs one frame of alternating 9 and 6 nibbles.
// - Entering low power while streaming powers down analogue, keeps registers.
// - Suspend pin high gates the clock and powers down analogue.
// - Soft reset bit 2 restores register defaults and enters low power.
// - Bytes are eight bits plus acknowledge, sampled on serial clock rise.
// - Start is data falling, stop is data rising, while clock high.
// - Matching address is acknowledged; its low bit is the direction.
// - First written byte is the index; its top bit enables auto-increment.
// - With auto-increment the index advances after each write data acknowledge and each master read acknowledge.
// - Received data byte is stored at the current index after acknowledge.
// - A read returns the index first, then addressed register contents.
// - After incremented runs the index stays one past the last access.
// - Master ends messages; the device then releases the data line.
// - A write with index and no data only updates the index.
// - Auto-increment write ends only on stop or repeated start.
// - Power and timing setup register is index 0x10, reset value 0x1.
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_sensor_ctrl
    import ssc_pkg::*;
#(
    parameter int FRAME_CYCLES = `SSC_FRAME_CYC,
    parameter int NUM_REGS = 128
) (
    input wire logic mclk,
    input wire logic rst,
    input wire ssc_bus_in_t busIn,
    input wire logic suspend,
    input wire logic clockRunning,
    output logic sdaOut,
    output logic sdaOe,
    output logic [3:0] nibbleBus,
    output logic analogueOn,
    output logic clockGated,
    output logic lowPower
);
    initial begin
        if (NUM_REGS != 128 || FRAME_CYCLES < 2) begin
            $error("ssc_sensor_ctrl: unsupported parameters");
        end
    end

    logic [7:0] regs_r [0:NUM_REGS-1];
    logic sclD_r, sdaD_r;
    logic [7:0] shift_r;
    logic [2:0] bitCnt_r;
    logic [6:0] index_r;
    logic autoInc_r;
    logic gotIdx_r;
    logic seenBit_r;
    logic idxPend_r;
    ssc_state_t st_r;
    ssc_pmode_t pm_r;
    logic [31:0] frameCnt_r;
    logic softRst;
    logic wakeReq;

    // Clock gate freezes all but the pins while suspended
    wire logic run = !suspend;
    wire logic sclRise = run && busIn.sclIn && !sclD_r;
    wire logic sclFall = run && !busIn.sclIn && sclD_r;
    wire logic startC = run && busIn.sclIn && sclD_r && sdaD_r && !busIn.sdaIn;
    wire logic stopC = run && busIn.sclIn && sclD_r && !sdaD_r && busIn.sdaIn;

    function automatic logic [7:0] rdByte(input logic [6:0] idx);
        rdByte = regs_r[idx];
    endfunction

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
        end else begin
            sclD_r <= busIn.sclIn;
            sdaD_r <= busIn.sdaIn;
        end
    end

    wire logic [7:0] shiftNxt = {shift_r[6:0], busIn.sdaIn};
    wire logic storeByte = sclFall && st_r == SS_ACKW && gotIdx_r;
    assign softRst = storeByte && index_r == `SSC_IDX_PWR && shift_r[`SSC_BIT_SRST];
    assign wakeReq = storeByte && index_r == `SSC_IDX_PWR && shift_r[`SSC_BIT_LP]
                     && clockRunning;

    // Serial protocol engine; slave only, clocked by edges of the master's clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= SS_IDLE;
            shift_r <= 8'h00;
            bitCnt_r <= 3'h0;
            index_r <= 7'h00;
            autoInc_r <= 1'b0;
            gotIdx_r <= 1'b0;
            seenBit_r <= 1'b0;
            idxPend_r <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
        end else if (startC) begin
            st_r <= SS_ADDR;
            bitCnt_r <= 3'h0;
            seenBit_r <= 1'b0;
            idxPend_r <= 1'b0;
            sdaOe <= 1'b0;
        end else if (stopC) begin
            st_r <= SS_IDLE;
            sdaOe <= 1'b0;
        end else if (sclRise) begin
            case (st_r)
                SS_ADDR, SS_INDEX, SS_WDATA: begin
                    shift_r <= shiftNxt;
                    bitCnt_r <= bitCnt_r + 3'h1;
                    // The fall closing a start carries no bit yet
                    seenBit_r <= 1'b1;
                end
                SS_RDATA: begin
                    bitCnt_r <= bitCnt_r + 3'h1;
                end
                SS_MACK: begin
                    // Master nack ends the read
                    if (busIn.sdaIn) begin
                        st_r <= SS_IGNORE;
                    end else begin
                        // Load only when the master asks for more, so the index ends one past
                        st_r <= SS_ACKR;
                        shift_r <= rdByte(index_r);
                        if (autoInc_r) begin
                            index_r <= index_r + 7'h1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            case (st_r)
                SS_ADDR: begin
                    if (bitCnt_r == 3'h0 && seenBit_r) begin
                        if (shift_r[7:1] == `SSC_ADDR_WR) begin
                            sdaOe <= 1'b1;
                            sdaOut <= 1'b0;
                            st_r <= shift_r[0] ? SS_ACKR : SS_ACKW;
                            gotIdx_r <= 1'b0;
                            idxPend_r <= !shift_r[0];
                            // Read answers with the index byte first
                            if (shift_r[0]) begin
                                shift_r <= {autoInc_r, index_r};
                            end
                        end else begin
                            st_r <= SS_IGNORE;
                        end
                    end
                end
                SS_INDEX, SS_WDATA: begin
                    if (bitCnt_r == 3'h0) begin
                        sdaOe <= 1'b1;
                        sdaOut <= 1'b0;
                        st_r <= SS_ACKW;
                    end
                end
                SS_ACKW: begin
                    sdaOe <= 1'b0;
                    // Address ack is not a data ack; the index byte follows
                    st_r <= idxPend_r ? SS_INDEX : SS_WDATA;
                    if (idxPend_r) begin
                        idxPend_r <= 1'b0;
                    end else if (!gotIdx_r) begin
                        // Index alone never touches a register
                        index_r <= shift_r[6:0];
                        autoInc_r <= shift_r[`SSC_IDX_MSB];
                        gotIdx_r <= 1'b1;
                    end else if (softRst) begin
                        index_r <= 7'h00;
                        autoInc_r <= 1'b0;
                    end else if (autoInc_r) begin
                        index_r <= index_r + 7'h1;
                    end
                end
                SS_ACKR, SS_RDATA: begin
                    if (st_r == SS_RDATA && bitCnt_r == 3'h0) begin
                        sdaOe <= 1'b0;
                        st_r <= SS_MACK;
                    end else begin
                        st_r <= SS_RDATA;
                        // Open drain: drive only zeros
                        sdaOe <= !shift_r[7];
                        sdaOut <= 1'b0;
                        shift_r <= {shift_r[6:0], 1'b0};
                    end
                end
                SS_MACK: begin
                end
                default: begin
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    // Register store; auto-incremented write ends only by bus events
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= (i == `SSC_IDX_PWR) ? `SSC_PWR_RST : 8'h00;
            end
        end else if (softRst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= (i == `SSC_IDX_PWR) ? `SSC_PWR_RST : 8'h00;
            end
        end else if (storeByte) begin
            regs_r[index_r] <= shift_r;
        end else if (pm_r != PM_LOW && run && regs_r[`SSC_IDX_PWR][`SSC_BIT_LP]) begin
            // Low-power bit written back: regs untouched except nothing
            regs_r[`SSC_IDX_PWR] <= regs_r[`SSC_IDX_PWR];
        end
    end

    // Power mode: low power on reset, soft reset, or bit 0 written clear while running
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pm_r <= PM_LOW;
            frameCnt_r <= 32'd0;
        end else if (softRst) begin
            pm_r <= PM_LOW;
        end else if (run) begin
            case (pm_r)
                PM_LOW: begin
                    if (wakeReq) begin
                        pm_r <= PM_INIT;
                        frameCnt_r <= 32'd0;
                    end
                end
                PM_INIT: begin
                    frameCnt_r <= frameCnt_r + 32'd1;
                    if (frameCnt_r == 32'(FRAME_CYCLES - 1)) begin
                        pm_r <= PM_RUN;
                    end
                end
                default: begin
                    if (storeByte && index_r == `SSC_IDX_PWR && !shift_r[`SSC_BIT_LP]) begin
                        pm_r <= PM_LOW;
                    end
                end
            endcase
        end
    end

    // Outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            nibbleBus <= `SSC_NIB_IDLE;
            analogueOn <= 1'b0;
            clockGated <= 1'b0;
            lowPower <= 1'b1;
        end else begin
            clockGated <= suspend;
            analogueOn <= !suspend && pm_r != PM_LOW;
            lowPower <= pm_r == PM_LOW;
            if (pm_r == PM_LOW) begin
                nibbleBus <= `SSC_NIB_IDLE;
            end else if (pm_r == PM_INIT) begin
                nibbleBus <= frameCnt_r[0] ? `SSC_NIB_B : `SSC_NIB_A;
            end else begin
                nibbleBus <= 4'h0;
            end
        end
    end

    AST_LP_NIBBLE: assert property (@(posedge mclk) disable iff (rst)
        lowPower |-> nibbleBus == `SSC_NIB_IDLE)
        else $error("nibble bus not idle in low power");
    AST_SUSP_ANA: assert property (@(posedge mclk) disable iff (rst)
        suspend |=> !analogueOn && clockGated)
        else $error("analogue on during suspend");
    AST_STOP_REL: assert property (@(posedge mclk) disable iff (rst)
        stopC |=> !sdaOe)
        else $error("data line held after stop");
    AST_INIT_PAT: assert property (@(posedge mclk) disable iff (rst)
        pm_r == PM_INIT && run |=> nibbleBus == `SSC_NIB_A || nibbleBus == `SSC_NIB_B)
        else $error("bad init pattern");
    AST_SRST_LP: assert property (@(posedge mclk) disable iff (rst)
        softRst |=> pm_r == PM_LOW ##1 lowPower)
        else $error("soft reset did not enter low power");
    AST_WAKE: assert property (@(posedge mclk) disable iff (rst)
        pm_r == PM_LOW && !wakeReq |=> pm_r == PM_LOW)
        else $error("left low power without wake");
    AST_IGN_REL: assert property (@(posedge mclk) disable iff (rst)
        st_r == SS_IGNORE |-> !sdaOe)
        else $error("data line driven in ignored message");
    AST_ADDR_ACK: assert property (@(posedge mclk) disable iff (rst)
        sclFall && st_r == SS_ADDR && seenBit_r && bitCnt_r == 3'h0
        && shift_r[7:1] == `SSC_ADDR_WR |=> sdaOe && !sdaOut)
        else $error("matching address not acknowledged");
    AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (rst)
        sdaOe |-> !sdaOut)
        else $error("data line driven high");
endmodule

// ### verification/ssc_i2c_master.sv
`timescale 1ns/1ps
module ssc_i2c_master #(
    parameter int HALF = 125
) (
    input wire logic mclk,
    input wire logic sdaLine,
    output logic sclM,
    output logic sdaM
);
    initial begin
        sclM = 1'b1;
        sdaM = 1'b1;
    end
    // Two halves per bit keep scl at 100 kHz
    task automatic hold();
        repeat (HALF) @(negedge mclk);
    endtask
    task automatic bitx(input logic b, output logic s);
        sdaM = b;
        hold();
        sclM = 1'b1;
        hold();
        s = sdaLine;
        sclM = 1'b0;
    endtask
    task automatic start();
        sdaM = 1'b1;
        hold();
        sclM = 1'b1;
        hold();
        sdaM = 1'b0;
        hold();
        sclM = 1'b0;
    endtask
    task automatic stop();
        sdaM = 1'b0;
        hold();
        sclM = 1'b1;
        hold();
        sdaM = 1'b1;
        hold();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        ack = ~s;
    endtask
    // Last byte of a read must carry mack low
    task automatic rbyte(output logic [7:0] b, input logic mack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
        bitx(~mack, s);
    endtask
endmodule

// ### verification/test_ssc_sensor_ctrl.sv
`timescale 1ns/1ps
module test_ssc_sensor_ctrl
    import ssc_pkg::*;
;
    localparam int FRAME = 8;
    logic mclk, rst, suspend, clockRunning, sclM, sdaM, sdaOut, sdaOe;
    logic analogueOn, clockGated, lowPower;
    logic [3:0] nibbleBus;
    wire logic sdaLine = sdaM & ~(sdaOe & ~sdaOut);
    ssc_bus_in_t busIn;
    int nFail = 0;
    int numChecks = 0;
    int cycles = 0;
    assign busIn.sclIn = sclM;
    assign busIn.sdaIn = sdaLine;
    ssc_sensor_ctrl #(.FRAME_CYCLES(FRAME), .NUM_REGS(128)) i_dut (.mclk(mclk), .rst(rst),
        .busIn(busIn), .suspend(suspend), .clockRunning(clockRunning), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .nibbleBus(nibbleBus), .analogueOn(analogueOn),
        .clockGated(clockGated), .lowPower(lowPower));
    ssc_i2c_master i_mst (.mclk(mclk), .sdaLine(sdaLine), .sclM(sclM), .sdaM(sdaM));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Whole run is about 90k cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 99000) begin
            nFail++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chkMode(input logic lp, input logic an, input logic [3:0] nib);
        chk("lowPower", {7'h0, lp}, {7'h0, lowPower});
        chk("analogueOn", {7'h0, an}, {7'h0, analogueOn});
        chk("nibbleBus", {4'h0, nib}, {4'h0, nibbleBus});
    endtask
    task automatic wb(input logic [7:0] b, input logic expAck);
        logic ack;
        i_mst.wbyte(b, ack);
        chk("ack", {7'h0, expAck}, {7'h0, ack});
    endtask
    task automatic rb(input logic [7:0] exp, input logic mack);
        logic [7:0] b;
        i_mst.rbyte(b, mack);
        chk("read byte", exp, b);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        i_mst.start();
        wb(8'h20, 1'b1);
        wb(idx, 1'b1);
        wb(data, 1'b1);
        i_mst.stop();
    endtask
    // Dataless write then repeated start, so the index is known
    task automatic rdAt(input logic [7:0] idx, input logic [7:0] exp);
        i_mst.start();
        wb(8'h20, 1'b1);
        wb(idx, 1'b1);
        i_mst.start();
        wb(8'h21, 1'b1);
        rb(idx, 1'b1);
        rb(exp, 1'b0);
        i_mst.stop();
    endtask
    task automatic t_wake();
        int k;
        clockRunning = 1'b1;
        fork
            wr(8'h10, 8'h01);
            begin
                k = 0;
                // The wake write alone takes about 7500 cycles
                while (nibbleBus === 4'hF && k < 20000) begin
                    @(negedge mclk);
                    k++;
                end
                for (int i = 0; i < FRAME; i++) begin
                    chk("init nibble", i[0] ? 8'h06 : 8'h09, {4'h0, nibbleBus});
                    @(negedge mclk);
                end
            end
        join
        chkMode(1'b0, 1'b1, 4'h0);
    endtask
    initial begin
        rst = 1'b1;
        suspend = 1'b0;
        clockRunning = 1'b0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        chkMode(1'b1, 1'b0, 4'hF);
        chk("sdaOe", 8'h00, {7'h0, sdaOe});
        i_mst.start();
        wb(8'h40, 1'b0);
        wb(8'h10, 1'b0);
        i_mst.stop();
        rdAt(8'h10, 8'h01);
        wr(8'h10, 8'h01);
        repeat (4) @(negedge mclk);
        chkMode(1'b1, 1'b0, 4'hF);
        t_wake();
        suspend = 1'b1;
        repeat (3) @(negedge mclk);
        chk("clockGated", 8'h01, {7'h0, clockGated});
        chk("analogueOn", 8'h00, {7'h0, analogueOn});
        suspend = 1'b0;
        repeat (3) @(negedge mclk);
        chk("clockGated", 8'h00, {7'h0, clockGated});
        i_mst.start();
        wb(8'h20, 1'b1);
        wb(8'hA0, 1'b1);
        wb(8'h55, 1'b1);
        wb(8'hAA, 1'b1);
        i_mst.stop();
        i_mst.start();
        wb(8'h21, 1'b1);
        rb(8'hA2, 1'b1);
        rb(8'h00, 1'b0);
        i_mst.stop();
        wr(8'h10, 8'h00);
        repeat (4) @(negedge mclk);
        chkMode(1'b1, 1'b0, 4'hF);
        i_mst.start();
        wb(8'h20, 1'b1);
        wb(8'hA0, 1'b1);
        i_mst.start();
        wb(8'h21, 1'b1);
        rb(8'hA0, 1'b1);
        rb(8'h55, 1'b1);
        rb(8'hAA, 1'b0);
        i_mst.stop();
        wr(8'h10, 8'h04);
        repeat (4) @(negedge mclk);
        chkMode(1'b1, 1'b0, 4'hF);
        rdAt(8'h21, 8'h00);
        final_report();
    end
endmodule
